// ==== dcf_pkg.sv ====
// constants, carriers and helpers of the fifo flag block
// assumes one clock for both fifo ports and an apb register slave
package dcf_pkg;

    // ***************************************
    // geometry
    // ***************************************
    localparam int DATA_W = 18;
    localparam int AW = 8;
    localparam int PW = 9;
    localparam int OFS_W = 12;
    localparam logic [PW-1:0] DEPTH_CNT = 9'h100;
    localparam logic [PW-1:0] HALF_CNT = 9'h080;
    localparam logic [AW-1:0] LAST_ADDR = 8'hff;

    // ***************************************
    // reset values and timing
    // ***************************************
    localparam logic [OFS_W-1:0] FULL_OFS_RST = 12'h01f;
    localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 12'h01f;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [1:0] STRAP_TAKE = 2'h2;

    // ***************************************
    // register map
    // ***************************************
    localparam logic [11:0] FULL_OFS_ADDR = 12'h000;
    localparam logic [11:0] EMPTY_OFS_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;
    localparam logic [11:0] LEVEL_ADDR = 12'h00c;
    localparam int ST_FULL = 0;
    localparam int ST_SPACE = 1;
    localparam int ST_AVAIL = 2;
    localparam int ST_OUTV = 3;
    localparam int ST_PAF = 4;
    localparam int ST_PAE = 5;
    localparam int ST_HF = 6;
    localparam int ST_FALL_THROUGH_MODE = 7;
    localparam int ST_PSYNC = 8;
    localparam int ST_CHAIN = 9;
    localparam int LV_WR = 0;
    localparam int LV_RD = 16;

    // ***************************************
    // carriers
    // ***************************************
    typedef struct packed {
        logic first_load_select_n;
        logic read_chain_in_n;
        logic write_chain_in_n;
    } dcf_strap_t;

    typedef struct packed {
        logic full_flag_n;
        logic empty_flag_n;
        logic almost_full_flag_n;
        logic almost_empty_flag_n;
        logic write_chain_out_n;
        logic read_chain_out_n;
    } dcf_flags_t;

    // ***************************************
    // pointer coding
    // ***************************************
    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == FULL_OFS_ADDR) || (a == EMPTY_OFS_ADDR) ||
               (a == STATUS_ADDR) || (a == LEVEL_ADDR);
    endfunction

endpackage

// ==== dcf_mem.sv ====
// word store of the fifo: one write port, one registered read port
// assumes the caller never reads and writes beyond its pointers
`timescale 1ns/10ps
module dcf_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [dcf_pkg::AW-1:0] wr_addr,
    input wire logic [dcf_pkg::DATA_W-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [dcf_pkg::AW-1:0] rd_addr,
    output logic [dcf_pkg::DATA_W-1:0] rd_data
);
    import dcf_pkg::*;

    logic [DATA_W-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    // output register clears on reset so the data pins read low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end

endmodule // dcf_mem

// ==== dcf_flag_fifo.sv ====
// fifo 256 x 18 with full, empty, partial, half-full and chain outputs
// assumes writer and reader run on pclk; straps come from board pins
//
// Summary of operation
// - standard full flag low at depth words
// - fall-through input ready high when memory full
// - full or input ready changes on write edges
// - standard empty flag low with no words
// - output ready falls with first word valid
// - output ready rises only on true read
// - empty or output ready changes on read edges
// - almost-full low at depth minus m
// - fall-through almost-full ignores the output register word except in the async clear
// - almost-full asynchronous or synchronous per strap
// - async almost-empty: read sets, write clears
// - sync almost-empty changes on read edges only
// - almost-empty at n, or n+1 fall-through
// - empty offset defaults to 31 words
// - write chain out shows half-full when single
// - half-full set by write, cleared by read
// - write chain pulse on last location write
// - read chain pulse on last location read
// - data pins low after reset when enabled
// - input ready falls on third edge after reset
// - first word readable after empty flag rises
// - writes ignored when full, reads when empty
// - reset clears pointers and presets all flags
// - first word falls through on third edge
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module dcf_flag_fifo (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // write port
    input wire logic wr_en_n,
    input wire logic [dcf_pkg::DATA_W-1:0] wr_data,
    // read port
    input wire logic rd_en_n,
    input wire logic output_enable_n,
    output logic [dcf_pkg::DATA_W-1:0] rd_data,
    output logic rd_data_oe,
    // straps
    input wire logic fall_through_mode,
    input wire dcf_pkg::dcf_strap_t straps,
    // flags
    output dcf_pkg::dcf_flags_t flags
);
    import dcf_pkg::*;

    // ***************************************
    // strap capture
    // ***************************************
    logic [3:0] strap_s1_ff;
    logic [3:0] strap_s2_ff;
    logic [1:0] cap_cnt_ff;
    logic fall_through_mode_ff;
    logic part_sync_ff;
    logic chain_ff;
    logic cfg_done;

    // pins are sampled in reset too, so the reset level of the empty pin follows the mode
    always_ff @(posedge pclk) begin
        strap_s1_ff <= {fall_through_mode, straps};
        strap_s2_ff <= strap_s1_ff;
    end

    // straps are read once after release and then held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cnt_ff <= '0;
            fall_through_mode_ff <= 1'b0;
            part_sync_ff <= 1'b0;
            chain_ff <= 1'b0;
        end else if (cap_cnt_ff != STRAP_WAIT) begin
            cap_cnt_ff <= cap_cnt_ff + 2'h1;
            if (cap_cnt_ff == STRAP_TAKE) begin
                fall_through_mode_ff <= strap_s2_ff[3];
                part_sync_ff <= strap_s2_ff[2] & ~(strap_s2_ff[1] & strap_s2_ff[0]);
                chain_ff <= strap_s2_ff[1] & strap_s2_ff[0];
            end
        end
    end

    assign cfg_done = (cap_cnt_ff == STRAP_WAIT);

    // ***************************************
    // pointers
    // ***************************************
    logic [PW-1:0] wptr_ff;
    logic [PW-1:0] wgray_ff;
    logic [PW-1:0] rptr_ff;
    logic [PW-1:0] rgray_ff;
    logic [PW-1:0] rq1_ff;
    logic [PW-1:0] rq2_ff;
    logic [PW-1:0] wq1_ff;
    logic [PW-1:0] wq2_ff;
    logic [PW-1:0] nxt_wptr;
    logic [PW-1:0] nxt_rptr;
    logic [PW-1:0] wlevel;
    logic [PW-1:0] nxt_wlevel;
    logic [PW-1:0] rlevel;
    logic [PW-1:0] nxt_rlevel;
    logic wr_go;
    logic rd_mem;
    logic full_ff;
    logic space_ff;
    logic avail_ff;
    logic outv_ff;
    logic wr_ok;
    logic load;

    assign wr_ok = fall_through_mode_ff ? space_ff : ~full_ff;
    assign wr_go = cfg_done & ~wr_en_n & wr_ok;
    assign nxt_wptr = wptr_ff + PW'(wr_go);
    assign nxt_rptr = rptr_ff + PW'(rd_mem);
    assign wlevel = wptr_ff - gray2bin(rq2_ff);
    assign nxt_wlevel = nxt_wptr - gray2bin(rq1_ff);
    assign rlevel = gray2bin(wq2_ff) - rptr_ff;
    assign nxt_rlevel = gray2bin(wq1_ff) - nxt_rptr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_ff <= '0;
            wgray_ff <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            wgray_ff <= bin2gray(nxt_wptr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_ff <= '0;
            rgray_ff <= '0;
        end else begin
            rptr_ff <= nxt_rptr;
            rgray_ff <= bin2gray(nxt_rptr);
        end
    end

    // each side sees the other pointer two stages late, so flags stay safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rq1_ff <= '0;
            rq2_ff <= '0;
            wq1_ff <= '0;
            wq2_ff <= '0;
        end else begin
            rq1_ff <= rgray_ff;
            rq2_ff <= rq1_ff;
            wq1_ff <= wgray_ff;
            wq2_ff <= wq1_ff;
        end
    end

    // ***************************************
    // word store
    // ***************************************
    dcf_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wr_go),
        .wr_addr(wptr_ff[AW-1:0]),
        .wr_data(wr_data),
        .rd_en(rd_mem),
        .rd_addr(rptr_ff[AW-1:0]),
        .rd_data(rd_data)
    );

    assign rd_data_oe = ~output_enable_n;

    // ***************************************
    // full and input ready
    // ***************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_ff <= 1'b0;
            space_ff <= 1'b0;
        end else begin
            full_ff <= (nxt_wlevel == DEPTH_CNT);
            space_ff <= (nxt_wlevel != DEPTH_CNT);
        end
    end

    // ***************************************
    // empty and output ready
    // ***************************************
    // fall-through keeps one word in the output register
    assign load = fall_through_mode_ff & cfg_done & (rlevel != '0) & (~outv_ff | ~rd_en_n);
    assign rd_mem = fall_through_mode_ff ? load : (cfg_done & ~rd_en_n & avail_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avail_ff <= 1'b0;
        end else begin
            avail_ff <= (nxt_rlevel != '0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outv_ff <= 1'b0;
        end else if (load) begin
            outv_ff <= 1'b1;
        end else if (~rd_en_n) begin
            outv_ff <= 1'b0;
        end
    end

    // ***************************************
    // partial and half-full flags
    // ***************************************
    logic paf_ff;
    logic pae_ff;
    logic hf_ff;
    logic [PW-1:0] thr_f;
    logic [PW-1:0] thr_e;
    logic [PW-1:0] nxt_rfill;
    logic nxt_outv;
    logic paf_hit;
    logic pae_hit;
    logic [OFS_W-1:0] full_ofs_ff;
    logic [OFS_W-1:0] empty_ofs_ff;

    assign nxt_outv = load | (outv_ff & rd_en_n);
    assign nxt_rfill = nxt_rlevel + PW'(fall_through_mode_ff & nxt_outv);
    // output word counts on both sides of the compare in fall-through
    assign thr_f = DEPTH_CNT - empty_pad(full_ofs_ff);
    assign thr_e = empty_pad(empty_ofs_ff) + PW'(fall_through_mode_ff);
    assign paf_hit = (nxt_wlevel >= thr_f);
    assign pae_hit = (nxt_rfill <= thr_e);

    function automatic logic [PW-1:0] empty_pad(input logic [OFS_W-1:0] o);
        return (o > OFS_W'(DEPTH_CNT)) ? DEPTH_CNT : o[PW-1:0];
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            paf_ff <= 1'b0;
        end else if (part_sync_ff) begin
            paf_ff <= paf_hit;
        end else if (paf_hit) begin
            paf_ff <= 1'b1;
        end else if (nxt_rfill < thr_f) begin
            paf_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pae_ff <= 1'b1;
        end else if (part_sync_ff) begin
            pae_ff <= pae_hit;
        end else if (pae_hit) begin
            pae_ff <= 1'b1;
        end else if (nxt_wlevel > thr_e) begin
            pae_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_ff <= 1'b0;
        end else if (nxt_wlevel > HALF_CNT) begin
            hf_ff <= 1'b1;
        end else if (nxt_rlevel <= HALF_CNT) begin
            hf_ff <= 1'b0;
        end
    end

    // ***************************************
    // chain pulses
    // ***************************************
    logic wxo_ff;
    logic rxo_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wxo_ff <= 1'b0;
            rxo_ff <= 1'b0;
        end else begin
            wxo_ff <= wr_go & (wptr_ff[AW-1:0] == LAST_ADDR);
            rxo_ff <= rd_mem & (rptr_ff[AW-1:0] == LAST_ADDR);
        end
    end

    // ***************************************
    // flag pins
    // ***************************************
    always_comb begin
        flags.full_flag_n = fall_through_mode_ff ? ~space_ff : ~full_ff;
        flags.empty_flag_n = fall_through_mode_ff ? ~outv_ff : (avail_ff | (~cfg_done & strap_s2_ff[3]));
        flags.almost_full_flag_n = ~paf_ff;
        flags.almost_empty_flag_n = ~pae_ff;
        flags.write_chain_out_n = chain_ff ? ~wxo_ff : ~hf_ff;
        flags.read_chain_out_n = ~(chain_ff & rxo_ff);
    end

    // ***************************************
    // apb registers
    // ***************************************
    logic wr_acc;
    logic [31:0] status;
    logic [31:0] level;

    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite & addr_hit(paddr);
    assign pslverr = psel & penable & ~addr_hit(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_ofs_ff <= FULL_OFS_RST;
            empty_ofs_ff <= EMPTY_OFS_RST;
        end else if (wr_acc && paddr == FULL_OFS_ADDR) begin
            full_ofs_ff <= pwdata[OFS_W-1:0];
        end else if (wr_acc && paddr == EMPTY_OFS_ADDR) begin
            empty_ofs_ff <= pwdata[OFS_W-1:0];
        end
    end

    always_comb begin
        status = '0;
        status[ST_FULL] = full_ff;
        status[ST_SPACE] = space_ff;
        status[ST_AVAIL] = avail_ff;
        status[ST_OUTV] = outv_ff;
        status[ST_PAF] = paf_ff;
        status[ST_PAE] = pae_ff;
        status[ST_HF] = hf_ff;
        status[ST_FALL_THROUGH_MODE] = fall_through_mode_ff;
        status[ST_PSYNC] = part_sync_ff;
        status[ST_CHAIN] = chain_ff;
        level = '0;
        level[LV_WR +: PW] = wlevel;
        level[LV_RD +: PW] = rlevel;
    end

    // read data is taken in the setup cycle and stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                FULL_OFS_ADDR: prdata <= {20'h00000, full_ofs_ff};
                EMPTY_OFS_ADDR: prdata <= {20'h00000, empty_ofs_ff};
                STATUS_ADDR: prdata <= status;
                LEVEL_ADDR: prdata <= level;
                default: prdata <= '0;
            endcase
        end
    end

    // ***************************************
    // assertions
    // ***************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_full_at_depth: assert property (cfg_done |-> (full_ff == (wlevel == DEPTH_CNT)))
        else $error("full flag does not match fill level");
    a_ir_at_depth: assert property (cfg_done && fall_through_mode_ff |-> (flags.full_flag_n == (wlevel == DEPTH_CNT)))
        else $error("input ready does not match fill level");
    a_no_overflow: assert property (wlevel <= DEPTH_CNT && rlevel <= DEPTH_CNT)
        else $error("fill level beyond depth");
    a_empty_blocks: assert property (!fall_through_mode_ff && !flags.empty_flag_n |-> !rd_mem)
        else $error("read taken while empty");
    a_first_fall: assert property (fall_through_mode_ff && wr_go && wlevel == '0 && rlevel == '0 && !outv_ff
        |-> ##4 outv_ff && !flags.empty_flag_n)
        else $error("first word did not fall through on third edge");
    a_or_holds: assert property (outv_ff && rd_en_n |=> outv_ff)
        else $error("output ready rose without a read");
    a_pae_sync: assert property (part_sync_ff |=> pae_ff == $past(pae_hit))
        else $error("sync almost-empty not updated");
    a_paf_set: assert property (paf_hit |=> !flags.almost_full_flag_n)
        else $error("almost-full not asserted at threshold");
    a_hf_set: assert property (nxt_wlevel > HALF_CNT |=> hf_ff)
        else $error("half-full not set");
    a_wchain_pulse: assert property (chain_ff && wr_go && wptr_ff[AW-1:0] == LAST_ADDR
        |=> !flags.write_chain_out_n)
        else $error("write chain pulse missing");

    c_fall_through: cover property (fall_through_mode_ff && $rose(outv_ff));
    c_full: cover property (!fall_through_mode_ff && $rose(full_ff));
    c_half: cover property ($rose(hf_ff) ##[1:600] $fell(hf_ff));
    c_chain: cover property (chain_ff && wxo_ff);

endmodule // dcf_flag_fifo

// ==== dcf_peer.sv ====
// far-side writer and reader of the fifo, plus the board straps
// assumes the bench raises wr_go or rd_go one cycle ahead of each request
`timescale 1ns/10ps
module dcf_peer #(
    parameter logic [dcf_pkg::DATA_W-1:0] SEQ0 = 18'h000a5
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // commands from the bench
    input wire logic wr_go,
    input wire logic rd_go,
    input wire logic ft_cfg,
    input wire dcf_pkg::dcf_strap_t strap_cfg,
    // fifo side
    output logic wr_en_n,
    output logic [dcf_pkg::DATA_W-1:0] wr_data,
    output logic rd_en_n,
    input wire logic [dcf_pkg::DATA_W-1:0] rd_data,
    input wire dcf_pkg::dcf_flags_t flags,
    output logic fall_through_mode,
    output dcf_pkg::dcf_strap_t straps,
    // results
    output logic [15:0] rd_cnt,
    output logic [15:0] ord_err
);
    import dcf_pkg::*;
    logic wr_ff;
    logic rd_ff;
    logic taken_ff;
    logic ft_ff;
    logic [DATA_W-1:0] seq_ff;
    logic [DATA_W-1:0] exp_ff;
    dcf_strap_t strap_ff;
    // ****
    // straps only change while reset is low
    // ****
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            ft_ff <= ft_cfg;
            strap_ff <= strap_cfg;
        end
    end
    assign fall_through_mode = presetn ? ft_ff : ft_cfg;
    assign straps = presetn ? strap_ff : strap_cfg;
    // ****
    // writer and reader
    // ****
    assign wr_en_n = ~(presetn & wr_ff);
    assign rd_en_n = ~(presetn & rd_ff);
    // idle bus carries the inverse word so stale data never passes for new
    assign wr_data = !presetn ? '0 : (wr_en_n ? ~seq_ff : seq_ff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            seq_ff <= SEQ0;
        end else begin
            wr_ff <= wr_go;
            rd_ff <= rd_go;
            seq_ff <= seq_ff + DATA_W'(!wr_en_n);
        end
    end
    // compares every taken word with the running sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_ff <= 1'b0;
            exp_ff <= SEQ0;
            rd_cnt <= '0;
            ord_err <= '0;
        end else begin
            taken_ff <= !fall_through_mode && !rd_en_n && flags.empty_flag_n;
            if (taken_ff || (fall_through_mode && !rd_en_n && !flags.empty_flag_n)) begin
                rd_cnt <= rd_cnt + 16'h1;
                exp_ff <= exp_ff + 1'b1;
                ord_err <= ord_err + 16'(rd_data !== exp_ff);
            end
        end
    end
endmodule // dcf_peer

// ==== testbench.sv ====
// self-checking bench of the fifo flag block
// assumes dcf_peer drives the fifo ports and pclk serves both sides
`timescale 1ns/10ps
module testbench;
    import dcf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wr_en_n;
    logic rd_en_n;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;
    logic output_enable_n = 1'b0;
    logic rd_data_oe;
    logic fall_through_mode;
    dcf_strap_t straps;
    dcf_flags_t flags;
    logic wr_go = 1'b0;
    logic rd_go = 1'b0;
    logic ft_cfg = 1'b0;
    dcf_strap_t strap_cfg = '0;
    logic [15:0] rd_cnt;
    logic [15:0] ord_err;
    int fails = 0;
    int checks_done = 0;
    int wx_lo;
    int rx_lo;

    always #12.5 pclk = ~pclk;

    dcf_flag_fifo DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n), .output_enable_n(output_enable_n),
        .rd_data(rd_data), .rd_data_oe(rd_data_oe), .fall_through_mode(fall_through_mode),
        .straps(straps), .flags(flags));

    dcf_peer peer (.pclk(pclk), .presetn(presetn), .wr_go(wr_go), .rd_go(rd_go), .ft_cfg(ft_cfg),
        .strap_cfg(strap_cfg), .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n),
        .rd_data(rd_data), .flags(flags), .fall_through_mode(fall_through_mode), .straps(straps),
        .rd_cnt(rd_cnt), .ord_err(ord_err));

    // counts cycles that each chain output spends low
    always @(posedge pclk) begin
        if (!presetn) begin
            wx_lo <= 0;
            rx_lo <= 0;
        end else begin
            wx_lo <= wx_lo + int'(flags.write_chain_out_n === 1'b0);
            rx_lo <= rx_lo + int'(flags.read_chain_out_n === 1'b0);
        end
    end

    // ****
    // shared tasks
    // ****
    task automatic test_done();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 32'h1, 32'h0);
            test_done();
        end
        @(posedge pclk);
    endtask

    task automatic do_reset(input logic ft, input dcf_strap_t st);
        presetn <= 1'b0;
        ft_cfg <= ft;
        strap_cfg <= st;
        repeat (20) @(posedge pclk);
        chk("reset flags", ft ? 32'h3b : 32'h2b, {26'h0, flags});
        chk("reset data", 32'h0, {14'h0, rd_data});
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask

    task automatic push(input int n);
        wr_go <= 1'b1;
        repeat (n) @(posedge pclk);
        wr_go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    task automatic pull(input int n);
        rd_go <= 1'b1;
        repeat (n) @(posedge pclk);
        rd_go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    task automatic step(input int n, input logic [5:0] e);
        push(n);
        chk("flags", {26'h0, e}, {26'h0, flags});
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, FULL_OFS_ADDR, 32'h0, q, e);
        chk("full ofs reset", 32'h1f, q);
        apb(1'b0, EMPTY_OFS_ADDR, 32'h0, q, e);
        chk("empty ofs reset", 32'h1f, q);
        apb(1'b1, FULL_OFS_ADDR, 32'haa, q, e);
        apb(1'b0, FULL_OFS_ADDR, 32'h0, q, e);
        chk("full ofs rw", 32'haa, q);
        apb(1'b1, FULL_OFS_ADDR, 32'h1f, q, e);
        apb(1'b1, 12'h010, 32'h5, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped data", 32'h0, q);
        output_enable_n <= 1'b1;
        @(posedge pclk);
        chk("oe off", 32'h0, {31'h0, rd_data_oe});
        output_enable_n <= 1'b0;
        @(posedge pclk);
        chk("oe on", 32'h1, {31'h0, rd_data_oe});
    endtask

    task automatic t_std();
        logic [31:0] q;
        logic e;
        step(31, 6'h3b);
        step(1, 6'h3f);
        step(96, 6'h3f);
        step(1, 6'h3d);
        step(95, 6'h3d);
        step(1, 6'h35);
        step(30, 6'h35);
        step(1, 6'h15);
        step(1, 6'h15);
        apb(1'b0, LEVEL_ADDR, 32'h0, q, e);
        chk("write level", 32'h100, q & 32'h1ff);
        pull(258);
        chk("read count", 32'd256, {16'h0, rd_cnt});
        chk("order errors", 32'h0, {16'h0, ord_err});
        chk("last word", 32'h1a4, {14'h0, rd_data});
        chk("drained flags", 32'h2b, {26'h0, flags});
        chk("read chain idle", 32'h0, rx_lo);
    endtask

    task automatic t_fall_through_mode();
        do_reset(1'b1, 3'b000);
        chk("ready after reset", 32'h1b, {26'h0, flags});
        wr_go <= 1'b1;
        @(posedge pclk);
        wr_go <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk("no word yet", 32'h1, {31'h0, flags.empty_flag_n});
        @(posedge pclk);
        #1;
        chk("word shown", 32'h0, {31'h0, flags.empty_flag_n});
        chk("first word", 32'ha5, {14'h0, rd_data});
        @(posedge pclk);
        step(224, 6'h0d);
        step(1, 6'h05);
        step(30, 6'h05);
        step(1, 6'h25);
        step(1, 6'h25);
        pull(259);
        chk("read count", 32'd257, {16'h0, rd_cnt});
        chk("order errors", 32'h0, {16'h0, ord_err});
        chk("last word kept", 32'h1a5, {14'h0, rd_data});
        chk("drained flags", 32'h1b, {26'h0, flags});
    endtask

    task automatic t_chain();
        do_reset(1'b0, 3'b011);
        push(256);
        chk("write chain pulses", 32'h1, wx_lo);
        pull(256);
        chk("read chain pulses", 32'h1, rx_lo);
    endtask

    task automatic t_sync();
        do_reset(1'b0, 3'b100);
        step(31, 6'h3b);
        step(1, 6'h3f);
        step(193, 6'h35);
        pull(194);
        chk("sync partial flags", 32'h3b, {26'h0, flags});
        pull(40);
        chk("sync read count", 32'd225, {16'h0, rd_cnt});
        chk("sync order errors", 32'h0, {16'h0, ord_err});
        chk("sync drained flags", 32'h2b, {26'h0, flags});
    endtask

    initial begin
        do_reset(1'b0, 3'b000);
        t_regs();
        t_std();
        t_fall_through_mode();
        t_chain();
        t_sync();
        test_done();
    end
endmodule // testbench
